// [core/byte_shifter.sv]
`timescale 1ns/1ps
`default_nettype none
`include "otp_prog_map.svh"

module byte_shifter
  import otp_prog_pkg::*;
(
  input  wire logic       clk_i,   // system clock
  input  wire logic       rst_i,   // sync reset, active high
  input  wire logic       start_i, // one-cycle request to send a byte
  input  wire logic [7:0] byte_i,  // byte, sent msb first
  input  wire logic       dc_i,    // data/command select for this byte
  output logic            busy_o,  // byte in flight
  output logic            done_o,  // pulse after the last falling edge
  output logic            sce_n_o, // chip enable, active low
  output logic            sclk_o,  // serial clock
  output logic            sdin_o,  // serial data
  output logic            dc_o     // data/command select pin
);

  logic [2:0] half_cnt; // cycles into the current half period
  logic [2:0] bit_idx;  // bit being presented
  logic [7:0] sh;       // shift register, msb on the pin

  //////////////////////////////////////////////////////////////////////////
  // serial engine: data changes only while sclk is low, so the device
  // sees a full half period of set-up before each rising edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o   <= 1'b0;
      done_o   <= 1'b0;
      sce_n_o  <= 1'b1;
      sclk_o   <= 1'b0;
      sdin_o   <= 1'b0;
      dc_o     <= 1'b0;
      half_cnt <= 3'd0;
      bit_idx  <= 3'd0;
      sh       <= 8'h00;
    end else begin
      done_o <= 1'b0;
      if (!busy_o) begin
        if (start_i) begin // open the frame, present bit 7
          busy_o   <= 1'b1;
          sce_n_o  <= 1'b0;
          dc_o     <= dc_i;
          sdin_o   <= byte_i[7];
          sh       <= byte_i;
          half_cnt <= 3'd0;
          bit_idx  <= 3'd0;
        end
      end else if (half_cnt != `SCLK_HALF - 3'd1) begin
        half_cnt <= half_cnt + 3'd1;
      end else begin
        half_cnt <= 3'd0;
        if (!sclk_o) begin
          sclk_o <= 1'b1; // device samples the bit here
        end else begin
          sclk_o <= 1'b0; // falling edge; after bit 7 the device moves bit 0 into the cell shift register
          if (bit_idx == 3'd7) begin
            busy_o  <= 1'b0;
            done_o  <= 1'b1;
            sce_n_o <= 1'b1;
          end else begin
            bit_idx <= bit_idx + 3'd1;
            sdin_o  <= sh[6];
            sh      <= {sh[6:0], 1'b0};
          end
        end
      end
    end
  end

endmodule // byte_shifter

`default_nettype wire

// [core/otp_prog_host.sv]
`timescale 1ns/1ps
`default_nettype none
`include "otp_prog_map.svh"

module otp_prog_host
  import otp_prog_pkg::*;
#(
  parameter int unsigned REFRESH_CYC = `T_REFRESH_MS * `CLK_KHZ,
  parameter int unsigned PULSE_CYC   = `T_PULSE_MS * `CLK_KHZ,
  parameter int unsigned SU_GATE_CYC = `T_SU_GATE_MS * `CLK_KHZ,
  parameter int unsigned HD_GATE_CYC = `T_HD_GATE_MS * `CLK_KHZ
) (
  input  wire logic        clk_i,         // 125 MHz system clock
  input  wire logic        rst_i,         // sync reset, active high
  // wishbone classic slave
  input  wire logic        cyc_i,         // bus cycle
  input  wire logic        stb_i,         // strobe
  input  wire logic        we_i,          // write enable
  input  wire logic [3:0]  adr_i,         // byte address
  input  wire logic [3:0]  sel_i,         // byte lanes
  input  wire logic [31:0] dat_i,         // write data
  output logic      [31:0] dat_o,         // read data
  output logic             ack_o,         // acknowledge
  // device pins
  output logic             dev_res_n_o,   // device reset, active low
  output logic             sce_n_o,       // serial chip enable, low
  output logic             sclk_o,        // serial clock
  output logic             sdin_o,        // serial data
  output logic             dc_o,          // data/command select
  output logic             prog_supply_o, // program supply pad enable
  output logic             lcd_supply_o   // display supply pad drive
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  seq_state_e  state;        // sequencer state
  cell_vec_t   pattern;      // bits to program, trim4 at [8], seal at [0]
  cell_vec_t   cells;        // cells this controller has programmed
  logic        pc_bit;       // power control bit sent in the refresh cmd
  logic        done;         // sticky: last operation finished
  logic        refused;      // sticky: last request refused
  logic        sealed;       // seal cell programmed
  logic [31:0] cnt;          // wait counter, counts down
  logic [3:0]  bit_no;       // cell byte being sent
  logic        launched;     // byte handed to the shifter
  logic        tx_start;     // one-cycle launch pulse
  logic [7:0]  tx_byte;      // byte to launch
  logic        tx_busy;      // shifter in flight
  logic        tx_done;      // shifter finished a byte
  logic        bus_req;      // fresh bus request this cycle
  logic        wr_ctrl;      // write to the control register
  logic        go_prog;      // start a programming pass
  logic        go_fin;       // start the closing reset

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // count of ones in a cell pattern
  function automatic logic [3:0] ones(input cell_vec_t v);
    logic [3:0] n;
    n = 4'd0;
    for (int i = 0; i < 9; i++) begin
      n = n + {3'd0, v[i]};
    end
    return n;
  endfunction

  // byte for a cell position: continuation, last-byte flag, data bit
  function automatic logic [7:0] cell_byte(input cell_vec_t v,
                                           input logic [3:0] k);
    logic [7:0] b;
    b = 8'h00;
    b[`CAL_CONT_BIT] = 1'b1;                    // stay in mode
    b[`CAL_LAST_BIT] = (k == 4'd8);
    b[0] = v[4'd8 - k];                         // trim4 first, seal last
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: ack one cycle after the strobe, dropped the next

  assign bus_req = cyc_i & stb_i & ~ack_o;
  assign wr_ctrl = bus_req & we_i & sel_i[0] & (adr_i == `OFS_CTRL);
  assign go_prog = wr_ctrl & dat_i[`CTRL_GO_PROG];
  assign go_fin  = wr_ctrl & dat_i[`CTRL_GO_FIN];

  // acknowledge every access, mapped or not
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= bus_req;
    end
  end

  // read data; unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0;
    end else if (bus_req && !we_i) begin
      unique case (adr_i)
        `OFS_CTRL: begin
          dat_o <= {29'h0, pc_bit, 2'b00};
        end
        `OFS_PATTERN: begin
          dat_o <= {23'h0, pattern};
        end
        `OFS_STATUS: begin
          dat_o <= {7'h0, cells, 8'h0, state, sealed, refused, done,
                    (state != ST_IDLE)};
        end
        default: begin
          dat_o <= 32'h0;
        end
      endcase
    end
  end

  // pattern and power control bit; frozen while a pass runs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pattern <= `PATTERN_RST;
      pc_bit  <= `PC_RST;
    end else if (bus_req && we_i && state == ST_IDLE) begin
      if (adr_i == `OFS_PATTERN) begin
        if (sel_i[0]) begin
          pattern[7:0] <= dat_i[7:0];
        end
        if (sel_i[1]) begin
          pattern[8] <= dat_i[8];
        end
      end
      if (wr_ctrl) begin
        pc_bit <= dat_i[`CTRL_PC];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial link to the device

  byte_shifter u_shift (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (tx_start),
    .byte_i  (tx_byte),
    .dc_i    (1'b0),
    .busy_o  (tx_busy),
    .done_o  (tx_done),
    .sce_n_o (sce_n_o),
    .sclk_o  (sclk_o),
    .sdin_o  (sdin_o),
    .dc_o    (dc_o)
  );

  // byte for the current sending state
  always_comb begin
    unique case (state)
      ST_FSET0: tx_byte = `CMD_FSET_RUN;
      ST_REF:   tx_byte = `CMD_POWER | {7'h0, pc_bit};
      ST_FSET1: tx_byte = `CMD_FSET_PD;
      ST_CAL:   tx_byte = `CMD_CAL_ENTER;
      ST_SHIFT: tx_byte = cell_byte(pattern, bit_no);
      default:  tx_byte = 8'h00;
    endcase
  end

  // launch once per byte of a sending state, when the shifter is free
  assign tx_start = !launched && !tx_busy &&
                    (state == ST_FSET0 || state == ST_REF ||
                     state == ST_FSET1 || state == ST_CAL ||
                     state == ST_SHIFT);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  // state walk; each wait loads cnt on entry and leaves at zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state    <= ST_IDLE;
      cnt      <= 32'h0;
      bit_no   <= 4'd0;
      launched <= 1'b0;
    end else begin
      if (tx_start) begin
        launched <= 1'b1;
      end
      unique case (state)
        ST_IDLE: begin
          // a refused request leaves the device untouched
          if (go_fin) begin
            state <= ST_FIN;
            cnt   <= 32'(`CYC_DEV_RES);
          end else if (go_prog && ones(pattern) == 4'd1 &&
                       (pattern & cells) == 9'h0 &&
                       !sealed) begin
            state <= ST_RESET;
            cnt   <= 32'(`CYC_DEV_RES);
          end
        end
        ST_RESET: begin
          // reset also clears bias and range, so the generator is off
          if (cnt == 32'h0) begin
            state <= ST_RES_GAP;
            cnt   <= 32'(`CYC_DEV_RES);
          end else begin
            cnt <= cnt - 32'h1;
          end
        end
        ST_RES_GAP: begin
          if (cnt == 32'h0) begin
            state <= ST_FSET0;
          end else begin
            cnt <= cnt - 32'h1;
          end
        end
        ST_FSET0: begin
          if (tx_done) begin
            state    <= ST_REF;
            launched <= 1'b0;
          end
        end
        ST_REF: begin
          if (tx_done) begin
            state    <= ST_REF_W;
            launched <= 1'b0;
            cnt      <= REFRESH_CYC;
          end
        end
        ST_REF_W: begin
          if (cnt == 32'h0) begin
            state <= ST_FSET1;
          end else begin
            cnt <= cnt - 32'h1;
          end
        end
        ST_FSET1: begin
          if (tx_done) begin
            state    <= ST_CAL;
            launched <= 1'b0;
          end
        end
        ST_CAL: begin
          if (tx_done) begin
            state    <= ST_SHIFT;
            launched <= 1'b0;
            bit_no   <= 4'd0;
          end
        end
        ST_SHIFT: begin
          if (tx_done) begin
            launched <= 1'b0;
            if (bit_no == 4'd8) begin
              state <= ST_INT_SU;
              cnt   <= 32'(`CYC_INT_SU);
            end else begin
              bit_no <= bit_no + 4'd1;
            end
          end
        end
        ST_INT_SU: begin
          if (cnt == 32'h0) begin
            state <= ST_SUP_ON;
            cnt   <= SU_GATE_CYC;
          end else begin
            cnt <= cnt - 32'h1;
          end
        end
        ST_SUP_ON: begin
          if (cnt == 32'h0) begin
            state <= ST_PULSE;
            cnt   <= PULSE_CYC;
          end else begin
            cnt <= cnt - 32'h1;
          end
        end
        ST_PULSE: begin
          if (cnt == 32'h0) begin
            state <= ST_SUP_HD;
            cnt   <= HD_GATE_CYC;
          end else begin
            cnt <= cnt - 32'h1;
          end
        end
        ST_SUP_HD: begin
          // the next serial clock is a full reset away, beyond the hold
          if (cnt == 32'h0) begin
            state <= ST_IDLE;
          end else begin
            cnt <= cnt - 32'h1;
          end
        end
        ST_FIN: begin
          if (cnt == 32'h0) begin
            state <= ST_IDLE;
          end else begin
            cnt <= cnt - 32'h1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins driven by the sequencer

  // device reset low in the opening and closing reset states
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dev_res_n_o <= 1'b1;
    end else begin
      dev_res_n_o <= !(state == ST_RESET || state == ST_FIN);
    end
  end

  // program supply spans set-up, pulse and hold
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prog_supply_o <= 1'b0;
    end else begin
      prog_supply_o <= (state == ST_SUP_ON || state == ST_PULSE ||
                        state == ST_SUP_HD);
    end
  end

  // display supply only during the pulse; the generator is off by reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lcd_supply_o <= 1'b0;
    end else begin
      lcd_supply_o <= (state == ST_PULSE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bookkeeping

  // shadow of programmed cells; only the 1 positions get burnt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cells  <= 9'h0;
      sealed <= 1'b0;
    end else if (state == ST_PULSE && cnt == 32'h0) begin
      cells  <= cells | pattern;
      sealed <= sealed | pattern[0];
    end
  end

  // sticky flags; done cleared by a go while idle, refused by any control write that is not itself refused
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done    <= 1'b0;
      refused <= 1'b0;
    end else begin
      if ((state == ST_SUP_HD || state == ST_FIN) && cnt == 32'h0) begin
        done <= 1'b1;
      end else if ((go_prog || go_fin) && state == ST_IDLE) begin
        done <= 1'b0;
      end
      if (go_prog && !go_fin && (state != ST_IDLE ||
          ones(pattern) != 4'd1 || (pattern & cells) != 9'h0 || sealed))
      begin
        refused <= 1'b1;
      end else if (wr_ctrl) begin
        refused <= 1'b0;
      end
    end
  end

endmodule // otp_prog_host

`default_nettype wire

// [core/otp_prog_map.svh]
`ifndef OTP_PROG_MAP_SVH
`define OTP_PROG_MAP_SVH

// register byte offsets on the wishbone side
`define OFS_CTRL      4'h0
`define OFS_PATTERN   4'h4
`define OFS_STATUS    4'h8

// control register fields
`define CTRL_GO_PROG  0
`define CTRL_GO_FIN   1
`define CTRL_PC       2

// status register fields
`define ST_BUSY       0
`define ST_DONE       1
`define ST_REFUSED    2
`define ST_SEALED     3
`define ST_STATE_LO   4
`define ST_CELLS_LO   16

// reset values
`define PATTERN_RST   9'h000
`define PC_RST        1'b0

// command bytes sent with data/command select low
`define CMD_FSET_RUN  8'h20
`define CMD_POWER     8'h12
`define CMD_FSET_PD   8'h25
`define CMD_CAL_ENTER 8'h1e
`define CAL_CONT_BIT  7
`define CAL_LAST_BIT  6

// timing figures as printed, and the clock rate
`define CLK_KHZ       125000
`define T_REFRESH_MS  5
`define T_PULSE_MS    120
`define T_SU_GATE_MS  2
`define T_HD_GATE_MS  2
`define T_INT_SU_US   1
`define T_INT_HD_US   1
`define T_DEV_RES_US  10
`define CYC_INT_SU    (`T_INT_SU_US * `CLK_KHZ / 1000)
`define CYC_INT_HD    (`T_INT_HD_US * `CLK_KHZ / 1000)
`define CYC_DEV_RES   (`T_DEV_RES_US * `CLK_KHZ / 1000)

// serial clock half period in system cycles (64 ns period)
`define SCLK_HALF     3'd4

`endif

// [core/otp_prog_pkg.sv]
package otp_prog_pkg;

  // sequencer states
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_RESET   = 4'h1,
    ST_RES_GAP = 4'h2,
    ST_FSET0   = 4'h3,
    ST_REF     = 4'h4,
    ST_REF_W   = 4'h5,
    ST_FSET1   = 4'h6,
    ST_CAL     = 4'h7,
    ST_SHIFT   = 4'h8,
    ST_INT_SU  = 4'h9,
    ST_SUP_ON  = 4'ha,
    ST_PULSE   = 4'hb,
    ST_SUP_HD  = 4'hc,
    ST_FIN     = 4'hd
  } seq_state_e;

  typedef logic [8:0] cell_vec_t;

endpackage

// [dv/otp_dev_model.sv]
`timescale 1ns/1ps
`default_nettype none

module otp_dev_model (
  input  wire logic       res_n_i, // device reset, low
  input  wire logic       sce_n_i, // chip enable, low
  input  wire logic       sclk_i,  // serial clock
  input  wire logic       sdin_i,  // serial data
  input  wire logic       prog_i,  // program supply on
  input  wire logic       lcd_i,   // display supply on
  output logic      [8:0] cells_o, // non-volatile cells
  output logic      [8:0] shreg_o, // cell shift register
  output logic            cal_o,   // calibration mode
  output logic            err_o    // bad programming pulse
);
  logic [7:0] sh;   // incoming byte
  int         n;    // bits taken in this frame
  logic       full; // byte complete, waits for last fall

  initial begin
    cells_o = '0;
    shreg_o = '0;
    cal_o   = 1'b0;
    err_o   = 1'b0;
    full    = 1'b0;
    n       = 0;
  end

  // bits taken on the rising clock; chip enable high restarts
  always @(posedge sclk_i or posedge sce_n_i) begin
    if (sce_n_i) begin
      n = 0;
    end else begin
      sh   = {sh[6:0], sdin_i};
      n    = n + 1;
      full = (n == 8);
    end
  end

  // a byte acts on its last falling edge; flag avoids racing sce_n
  always @(negedge sclk_i) begin
    if (full) begin
      full = 1'b0;
      if (cal_o) begin
        shreg_o = {shreg_o[7:0], sh[0]};
        cal_o   = sh[7];
      end else if (sh == 8'h1e) begin
        cal_o = !cells_o[0];
      end else if (sh[7:1] == 7'h09) begin
        shreg_o = cells_o;               // reload at once, not in 5 ms
      end
    end
  end

  // reset leaves calibration mode
  always @(negedge res_n_i) begin
    cal_o = 1'b0;
  end

  // display supply joining the program supply is the pulse
  always @(posedge lcd_i) begin
    if (!prog_i || !cal_o || (cells_o & shreg_o) != '0 ||
        $countones(shreg_o) != 1) err_o = 1'b1;
    cells_o = cells_o | shreg_o;
  end
endmodule // otp_dev_model
`default_nettype wire

// [dv/otp_prog_host_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
`include "otp_prog_map.svh"

module otp_prog_host_asserts #(
  parameter int unsigned REFRESH_CYC = `T_REFRESH_MS * `CLK_KHZ, // refresh
  parameter int unsigned PULSE_CYC   = `T_PULSE_MS * `CLK_KHZ,   // pulse
  parameter int unsigned SU_GATE_CYC = `T_SU_GATE_MS * `CLK_KHZ, // set-up
  parameter int unsigned HD_GATE_CYC = `T_HD_GATE_MS * `CLK_KHZ  // hold
) (
  input wire logic clk_i,         // system clock
  input wire logic rst_i,         // sync reset
  input wire logic cyc_i,         // bus cycle
  input wire logic stb_i,         // strobe
  input wire logic ack_o,         // acknowledge
  input wire logic dev_res_n_o,   // device reset, low
  input wire logic sce_n_o,       // chip enable, low
  input wire logic sclk_o,        // serial clock
  input wire logic sdin_o,        // serial data
  input wire logic dc_o,          // data/command select
  input wire logic prog_supply_o, // program supply
  input wire logic lcd_supply_o   // display supply
);
  int unsigned idle;   // cycles with chip enable high
  int unsigned frames; // bytes since device reset
  int unsigned pcnt;   // cycles program supply high
  int unsigned lcnt;   // cycles display supply high
  int unsigned lgap;   // cycles display supply low

  //////////////////////////////////////////////////////////////////////////
  // run lengths; 32 bits so nothing wraps within a run
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idle <= 0;
      pcnt <= 0;
      lcnt <= 0;
      lgap <= 0;
    end else begin
      idle <= sce_n_o ? idle + 1 : 0;
      pcnt <= prog_supply_o ? pcnt + 1 : 0;
      lcnt <= lcd_supply_o ? lcnt + 1 : 0;
      lgap <= lcd_supply_o ? 0 : lgap + 1;
    end
  end

  // byte count restarts with every device reset
  always_ff @(posedge clk_i) begin
    if (rst_i || !dev_res_n_o) frames <= 0;
    else if ($rose(sce_n_o)) frames <= frames + 1;
  end

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ack;
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus answer not a single cycle");
  property p_dc_low;
    !dc_o;
  endproperty
  a_dc_low: assert property (p_dc_low)
    else $error("dc select not low");
  property p_sclk_frame;
    sce_n_o |-> !sclk_o;
  endproperty
  a_sclk_frame: assert property (p_sclk_frame)
    else $error("serial clock outside a frame");
  property p_sdin_low;
    $changed(sdin_o) |-> !sclk_o;
  endproperty
  a_sdin_low: assert property (p_sdin_low)
    else $error("data moved while clock high");
  property p_refresh;
    $fell(sce_n_o) && frames == 2 |-> idle >= REFRESH_CYC;
  endproperty
  a_refresh: assert property (p_refresh)
    else $error("refresh wait too short");
  property p_setup;
    $rose(prog_supply_o) |-> idle >= `CYC_INT_SU && frames == 13;
  endproperty
  a_setup: assert property (p_setup)
    else $error("supply raised too early");
  property p_hold;
    $fell(sce_n_o) |-> !prog_supply_o && lgap > `CYC_INT_HD;
  endproperty
  a_hold: assert property (p_hold)
    else $error("shifting too close to a pulse");
  property p_lcd_gate;
    lcd_supply_o |-> prog_supply_o && sce_n_o;
  endproperty
  a_lcd_gate: assert property (p_lcd_gate)
    else $error("display supply outside gate");
  property p_su_gate;
    $rose(lcd_supply_o) |-> pcnt >= SU_GATE_CYC && pcnt <= SU_GATE_CYC + 3;
  endproperty
  a_su_gate: assert property (p_su_gate)
    else $error("supply set-up out of range");
  property p_pulse;
    $fell(lcd_supply_o) |-> lcnt >= PULSE_CYC && lcnt <= PULSE_CYC + 3;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("pulse width out of range");
  property p_hd_gate;
    $fell(prog_supply_o) |-> lgap >= HD_GATE_CYC && lgap <= HD_GATE_CYC + 3;
  endproperty
  a_hd_gate: assert property (p_hd_gate)
    else $error("supply hold out of range");
endmodule // otp_prog_host_asserts

bind otp_prog_host otp_prog_host_asserts #(
  .REFRESH_CYC(REFRESH_CYC), .PULSE_CYC(PULSE_CYC),
  .SU_GATE_CYC(SU_GATE_CYC), .HD_GATE_CYC(HD_GATE_CYC)
) u_asserts (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .ack_o(ack_o), .dev_res_n_o(dev_res_n_o), .sce_n_o(sce_n_o),
  .sclk_o(sclk_o), .sdin_o(sdin_o), .dc_o(dc_o),
  .prog_supply_o(prog_supply_o), .lcd_supply_o(lcd_supply_o)
);
`default_nettype wire

// [dv/otp_prog_host_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "otp_prog_map.svh"

module otp_prog_host_tb_top;
  localparam int LIMIT = 60000; // hang ceiling in cycles
  logic        clk = 1'b0;  // 125 MHz
  logic        rst = 1'b1;  // sync reset
  logic        cyc = 1'b0;  // bus cycle
  logic        stb = 1'b0;  // strobe
  logic        we  = 1'b0;  // write enable
  logic [3:0]  adr = '0;    // address
  logic [3:0]  sel = '0;    // lanes
  logic [31:0] dat = '0;    // write data
  logic [31:0] rdat;        // read data
  logic        ack, res_n, sce_n, sclk, sdin, dc, psup, lsup;
  logic [8:0]  cells, shreg; // device state
  logic        cal, err;     // device flags
  int          fail_count = 0;
  int          checks_done = 0;
  int          cyc_cnt = 0;

  always #4 clk = ~clk;

  // short counts keep a pass near 4000 cycles
  otp_prog_host #(.REFRESH_CYC(50), .PULSE_CYC(200), .SU_GATE_CYC(20),
    .HD_GATE_CYC(20)) dut (
    .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack),
    .dev_res_n_o(res_n), .sce_n_o(sce_n), .sclk_o(sclk), .sdin_o(sdin),
    .dc_o(dc), .prog_supply_o(psup), .lcd_supply_o(lsup));

  otp_dev_model dev (.res_n_i(res_n), .sce_n_i(sce_n), .sclk_i(sclk),
    .sdin_i(sdin), .prog_i(psup), .lcd_i(lsup), .cells_o(cells),
    .shreg_o(shreg), .cal_o(cal), .err_o(err));

  //////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    if (fail_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
      fail_count++;
    end
  endtask

  // one classic cycle; ack and data taken at the same edge
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int t;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (ack !== 1'b1 && t < 50);
    q = rdat;
    chk("ack", {31'h0, ack}, 1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // poll status until the pass is over
  task automatic wait_idle(output logic [31:0] s);
    for (int k = 0; k < 500; k++) begin
      repeat (20) @(posedge clk);
      wb(0, `OFS_STATUS, 0, s);
      if (s[`ST_BUSY] === 1'b0) break;
    end
  endtask

  task automatic go(input logic [31:0] p, output logic [31:0] s);
    wb(1, `OFS_PATTERN, p, s);
    wb(1, `OFS_CTRL, 32'h5, s);
    wait_idle(s);
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [31:0] q;
    wb(0, `OFS_STATUS, 0, q);
    chk("status", q, 0);
    wb(0, `OFS_PATTERN, 0, q);
    chk("pattern", q, {23'h0, `PATTERN_RST});
    wb(0, `OFS_CTRL, 0, q);
    chk("pc", {31'h0, q[`CTRL_PC]}, {31'h0, `PC_RST});
    wb(0, 4'hc, 0, q); // unmapped, must still answer
    chk("unmapped", q, 0);
  endtask

  // a pass with writes arriving while busy
  task automatic t_prog;
    logic [31:0] q;
    wb(1, `OFS_PATTERN, 32'h100, q);
    wb(1, `OFS_CTRL, 32'h5, q);
    wb(1, `OFS_PATTERN, 32'h001, q);
    wb(1, `OFS_CTRL, 32'h1, q);
    wait_idle(q);
    chk("flags", {28'h0, q[3:0]}, 32'h6);
    chk("shadow", {23'h0, q[24:16]}, 32'h100);
    chk("cells", {23'h0, cells}, 32'h100);
    chk("shreg", {23'h0, shreg}, 32'h100);
    chk("cal", {31'h0, cal}, 1);
    wb(0, `OFS_PATTERN, 0, q);
    chk("pattern", q, 32'h100);
    wb(0, `OFS_CTRL, 0, q);
    chk("pc", q, 32'h4);
  endtask

  // patterns with two ones, a programmed one and none are refused
  task automatic t_refuse;
    logic [31:0] q;
    logic [31:0] pats [3] = '{32'h003, 32'h100, 32'h000};
    foreach (pats[i]) begin
      wb(1, `OFS_CTRL, 32'h4, q);
      wb(0, `OFS_STATUS, 0, q);
      chk("cleared", {31'h0, q[`ST_REFUSED]}, 0);
      wb(1, `OFS_PATTERN, pats[i], q);
      wb(1, `OFS_CTRL, 32'h5, q);
      wb(0, `OFS_STATUS, 0, q);
      // any go seen while idle clears done, a refused one as well
      chk("refused", {28'h0, q[3:0]}, 32'h4);
    end
    chk("cells", {23'h0, cells}, 32'h100);
  endtask

  // a maker bit, then the seal, then nothing more
  task automatic t_seal;
    logic [31:0] q;
    go(32'h004, q);
    chk("shadow", {23'h0, q[24:16]}, 32'h104);
    go(32'h001, q);
    chk("sealed", {28'h0, q[3:0]}, 32'ha);
    chk("cells", {23'h0, cells}, 32'h105);
    wb(1, `OFS_PATTERN, 32'h002, q);
    wb(1, `OFS_CTRL, 32'h5, q);
    wb(0, `OFS_STATUS, 0, q);
    chk("after", {28'h0, q[3:0]}, 32'hc);
  endtask

  // closing device reset leaves calibration mode
  task automatic t_fin;
    logic [31:0] q;
    wb(1, `OFS_CTRL, 32'h2, q);
    wait_idle(q);
    chk("done", {30'h0, q[1:0]}, 32'h2);
    chk("cal", {31'h0, cal}, 0);
    chk("err", {31'h0, err}, 0);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // hang guard
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == LIMIT) begin
      fail_count++;
      final_report;
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_prog;
    t_refuse;
    t_seal;
    t_fin;
    final_report;
  end
endmodule // otp_prog_host_tb_top
`default_nettype wire
